/* src/ftc_pkg.sv */
/*
 * ftc_pkg: constants shared by the fault tolerant can transceiver control
 * logic: clock rate, timing figures, derived cycle counts, apb map, fields.
 * assumes a single 40 mhz clock; all times are given in nanoseconds.
 */
package ftc_pkg;
    // ==========================================================
    // clock
    localparam int CLK_NS          = 25;
    // ==========================================================
    // timing figures, as printed, in ns
    localparam int TXD_TO_MIN_NS   = 750_000;  // dominant timeout, least
    localparam int WAKE_DEB_NS     = 7_000;    // wake pin debounce, least
    localparam int GTS_HOLD_NS     = 5_000;    // go-to-sleep hold, least
    localparam int CAN_BIT_NS      = 8_000;    // one bit at 125 kbit/s
    localparam int REM_WAKE_BITS   = 5;        // dominant bits for remote wake
    localparam int FAIL_ON_NS      = 40_000;   // single-wire entry filter
    localparam int FAIL_OFF_NS     = 40_000;   // return to differential delay
    // ==========================================================
    // derived counts, least times round up
    localparam int TXD_TO_CYC   = (TXD_TO_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_DEB_CYC = (WAKE_DEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int GTS_HOLD_CYC = (GTS_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int REM_WAKE_CYC = (REM_WAKE_BITS * CAN_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAIL_ON_CYC  = (FAIL_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAIL_OFF_CYC = (FAIL_OFF_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================================
    // apb register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // ctrl fields
    localparam int CTRL_TXD_TO_EN  = 0;
    localparam int CTRL_REM_WAKE_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    // status fields
    localparam int ST_MODE_LSB   = 0;
    localparam int ST_WIRE_H     = 8;
    localparam int ST_WIRE_L     = 9;
    localparam int ST_SOFT       = 10;
    localparam int ST_TXD_TO     = 11;
    localparam int ST_PWRON      = 12;
    localparam int ST_WAKE       = 13;
    localparam int ST_OVERTEMP   = 14;
    // ==========================================================
    // operating modes, one-hot
    typedef enum logic [4:0] {
        MODE_NORMAL  = 5'h01,
        MODE_PWRON   = 5'h02,
        MODE_GTS     = 5'h04,
        MODE_STANDBY = 5'h08,
        MODE_SLEEP   = 5'h10
    } ftc_mode_t;
endpackage

/* src/ftc_sync.sv */
/*
 * ftc_sync: two flip-flop synchroniser for a bus of independent levels.
 * assumes each bit is a slow level; no multi-bit coherence is promised.
 */
`timescale 1ns/1ps
module ftc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* src/ftc_persist.sv */
/*
 * ftc_persist: level filter; the output follows the input only after the
 * new level has stood for ON_CYC (to high) or OFF_CYC (to low) cycles.
 * assumes a synchronised input in the pclk domain.
 */
`timescale 1ns/1ps
module ftc_persist #(
    parameter int ON_CYC  = 1,
    parameter int OFF_CYC = 1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic level_in,
    output logic      level_out
);
    localparam int CW = $clog2((ON_CYC > OFF_CYC ? ON_CYC : OFF_CYC) + 1);
    localparam logic [CW-1:0] ON_LIM  = CW'(ON_CYC - 1);
    localparam logic [CW-1:0] OFF_LIM = CW'(OFF_CYC - 1);

    logic [CW-1:0] cnt_q;

    // ==========================================================
    // count while input differs; any glitch back restarts the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= '0;
            level_out <= 1'b0;
        end else if (level_in == level_out) begin
            cnt_q <= '0;
        end else if (cnt_q == (level_in ? ON_LIM : OFF_LIM)) begin
            cnt_q     <= '0;
            level_out <= level_in;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule

/* src/ftc_ctrl.sv */
/*
 * ftc_ctrl: digital control of a fault tolerant low-speed can transceiver:
 * dominant timeout, failure handling, low-power modes, wake-up, supplies,
 * thermal flag, and an apb slave with a control and a status register.
 * assumes analog detectors deliver asynchronous levels on the pin inputs.
 */
`timescale 1ns/1ps
module ftc_ctrl #(
    parameter int TXD_TO_CYC = ftc_pkg::TXD_TO_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // controller side pins
    input  wire logic        txd_n,
    input  wire logic        standby_ctrl_n,
    input  wire logic        mode_en,
    output logic             rxd,
    output logic             err_n,
    // wake pin and analog detector levels
    input  wire logic        wake_pin,
    input  wire logic        bus_rx,
    input  wire logic        bus_dom_h,
    input  wire logic        bus_dom_l,
    input  wire logic        fail_soft,
    input  wire logic        fail_wire_h,
    input  wire logic        fail_wire_l,
    input  wire logic        vcc_low,
    input  wire logic        vbat_low,
    input  wire logic        overtemp,
    // bus side drives
    output logic             drive_h,
    output logic             drive_l,
    output logic             term_h_en,
    output logic             term_l_en,
    output logic             low_line_termination,
    output logic             regulator_switch_out,
    output logic             regulator_switch_oe
);
    localparam int NIN = 13;
    localparam int TW  = $clog2(TXD_TO_CYC + 1);
    localparam int GW  = $clog2(ftc_pkg::GTS_HOLD_CYC + 1);
    localparam logic [TW-1:0] TXD_LIM = TW'(TXD_TO_CYC - 1);
    localparam logic [GW-1:0] GTS_LIM = GW'(ftc_pkg::GTS_HOLD_CYC - 1);

    // ==========================================================
    // input synchronisation
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] s_in;
    assign raw_in = {txd_n, standby_ctrl_n, mode_en, wake_pin, bus_rx, bus_dom_h,
                     bus_dom_l, fail_soft, fail_wire_h, fail_wire_l, vcc_low,
                     vbat_low, overtemp};

    ftc_sync #(.WIDTH(NIN)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_in),
        .sync_out (s_in)
    );

    logic txd_s, sby_s, en_s, wake_s, rx_s, dom_h_s, dom_l_s;
    logic soft_s, wire_h_s, wire_l_s, vcc_low_s, vbat_low_s, otemp_s;
    assign {txd_s, sby_s, en_s, wake_s, rx_s, dom_h_s, dom_l_s, soft_s,
            wire_h_s, wire_l_s, vcc_low_s, vbat_low_s, otemp_s} = s_in;

    // ==========================================================
    // state declarations
    ftc_pkg::ftc_mode_t mode_q, mode_d;
    logic [TW-1:0] txd_cnt_q;
    logic          txd_to_q;
    logic [GW-1:0] gts_cnt_q;
    logic          pwron_q;
    logic          wake_flag_q;
    logic [1:0]    ctrl_q;
    logic          wake_deb, wake_deb_q, rem_deb, rem_deb_q;
    logic          wire_h_f, wire_l_f, soft_f;
    logic          wake_evt, low_power, sby_eff, en_eff;

    // ==========================================================
    // failure filters; wire faults stay watched in low power, soft ones not
    ftc_persist #(.ON_CYC(ftc_pkg::FAIL_ON_CYC), .OFF_CYC(ftc_pkg::FAIL_OFF_CYC)) u_fh (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (wire_h_s),
        .level_out (wire_h_f)
    );
    ftc_persist #(.ON_CYC(ftc_pkg::FAIL_ON_CYC), .OFF_CYC(ftc_pkg::FAIL_OFF_CYC)) u_fl (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (wire_l_s),
        .level_out (wire_l_f)
    );
    ftc_persist #(.ON_CYC(ftc_pkg::FAIL_ON_CYC), .OFF_CYC(ftc_pkg::FAIL_OFF_CYC)) u_fs (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (soft_s && !low_power),
        .level_out (soft_f)
    );

    // ==========================================================
    // wake sources: debounced pin level, five dominant bit times on bus
    ftc_persist #(.ON_CYC(ftc_pkg::WAKE_DEB_CYC), .OFF_CYC(ftc_pkg::WAKE_DEB_CYC)) u_wk (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (wake_s),
        .level_out (wake_deb)
    );
    ftc_persist #(.ON_CYC(ftc_pkg::REM_WAKE_CYC), .OFF_CYC(1)) u_rw (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (dom_h_s || dom_l_s),
        .level_out (rem_deb)
    );

    // previous filtered levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_deb_q <= 1'b0;
            rem_deb_q  <= 1'b0;
        end else begin
            wake_deb_q <= wake_deb;
            rem_deb_q  <= rem_deb;
        end
    end

    // both edges of the pin count, remote wake can be masked by software
    assign wake_evt = low_power && ((wake_deb != wake_deb_q)
                    || (rem_deb && !rem_deb_q && ctrl_q[ftc_pkg::CTRL_REM_WAKE_EN]));

    // ==========================================================
    // fail-safe view of the mode pins
    assign sby_eff   = sby_s && !vcc_low_s && !vbat_low_s;
    assign en_eff    = en_s && !vcc_low_s && !vbat_low_s;
    assign low_power = (mode_q != ftc_pkg::MODE_NORMAL);

    // ==========================================================
    // mode selection
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ftc_pkg::MODE_SLEEP: begin
                // once asleep only a wake or the controller leaves sleep
                if (sby_eff && en_eff)                mode_d = ftc_pkg::MODE_NORMAL;
                else if (sby_eff)                     mode_d = ftc_pkg::MODE_PWRON;
                else if (wake_evt)                    mode_d = ftc_pkg::MODE_STANDBY;
            end
            ftc_pkg::MODE_GTS: begin
                if (sby_eff && en_eff)                mode_d = ftc_pkg::MODE_NORMAL;
                else if (sby_eff)                     mode_d = ftc_pkg::MODE_PWRON;
                else if (wake_evt || !en_eff)         mode_d = ftc_pkg::MODE_STANDBY;
                else if (gts_cnt_q == GTS_LIM)        mode_d = ftc_pkg::MODE_SLEEP;
            end
            default: begin
                // follow the pins; a pending wake blocks a new go-to-sleep
                if (sby_eff && en_eff)                mode_d = ftc_pkg::MODE_NORMAL;
                else if (sby_eff)                     mode_d = ftc_pkg::MODE_PWRON;
                else if (en_eff && !wake_flag_q)      mode_d = ftc_pkg::MODE_GTS;
                else                                  mode_d = ftc_pkg::MODE_STANDBY;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mode_q <= ftc_pkg::MODE_STANDBY;
        else          mode_q <= mode_d;
    end

    // go-to-sleep hold timer, restarts on each entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                         gts_cnt_q <= '0;
        else if (mode_q != ftc_pkg::MODE_GTS) gts_cnt_q <= '0;
        else if (gts_cnt_q != GTS_LIM)        gts_cnt_q <= gts_cnt_q + GW'(1);
    end

    // ==========================================================
    // dominant timeout; released when txd goes recessive or a low-power mode is entered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_cnt_q <= '0;
            txd_to_q  <= 1'b0;
        end else if (txd_s || low_power) begin
            txd_cnt_q <= '0;
            txd_to_q  <= 1'b0;
        end else if (txd_cnt_q == TXD_LIM) begin
            txd_to_q  <= ctrl_q[ftc_pkg::CTRL_TXD_TO_EN];
        end else begin
            txd_cnt_q <= txd_cnt_q + TW'(1);
        end
    end

    // ==========================================================
    // power-on and wake flags; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                            pwron_q <= 1'b1;
        else if (vbat_low_s)                     pwron_q <= 1'b1;
        else if (mode_q == ftc_pkg::MODE_NORMAL) pwron_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                            wake_flag_q <= 1'b0;
        else if (wake_evt)                       wake_flag_q <= 1'b1;
        else if (mode_q == ftc_pkg::MODE_NORMAL) wake_flag_q <= 1'b0;
    end

    // ==========================================================
    // bus drivers and terminations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_h              <= 1'b0;
            drive_l              <= 1'b0;
            term_h_en            <= 1'b1;
            term_l_en            <= 1'b1;
            low_line_termination <= 1'b1;
        end else begin
            // soft failures leave both drivers on
            drive_h <= !low_power && !txd_s && !txd_to_q && !otemp_s && !wire_h_f;
            drive_l <= !low_power && !txd_s && !txd_to_q && !otemp_s && !wire_l_f;
            term_h_en            <= !wire_h_f;
            term_l_en            <= !wire_l_f;
            low_line_termination <= low_power;
        end
    end

    // ==========================================================
    // regulator switch: floated only in sleep unless battery is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_switch_out <= 1'b1;
            regulator_switch_oe  <= 1'b1;
        end else begin
            regulator_switch_out <= 1'b1;
            regulator_switch_oe  <= (mode_d != ftc_pkg::MODE_SLEEP) || vbat_low_s;
        end
    end

    // ==========================================================
    // receive and error outputs per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd   <= 1'b1;
            err_n <= 1'b1;
        end else if (!low_power) begin
            rxd   <= rx_s;
            err_n <= !(wire_h_f || wire_l_f || soft_f || otemp_s);
        end else if (mode_q == ftc_pkg::MODE_PWRON) begin
            rxd   <= !wake_flag_q;
            err_n <= !pwron_q;
        end else begin
            rxd   <= !wake_flag_q || vcc_low_s;
            err_n <= !wake_flag_q || vcc_low_s;
        end
    end

    // ==========================================================
    // apb slave: one wait-free access, answer registered in setup
    logic [31:0] status_w;
    logic        hit;
    assign status_w = {17'h0, otemp_s, wake_flag_q, pwron_q, txd_to_q, soft_f,
                       wire_l_f, wire_h_f, 3'h0, mode_q};
    assign hit = (paddr == ftc_pkg::ADDR_CTRL) || (paddr == ftc_pkg::ADDR_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite && paddr == ftc_pkg::ADDR_CTRL)
                prdata <= {30'h0, ctrl_q};
            else if (psel && !penable && !pwrite && paddr == ftc_pkg::ADDR_STATUS)
                prdata <= status_w;
            else
                prdata <= 32'h0;
        end
    end

    // control register; writes land at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= ftc_pkg::CTRL_RESET;
        else if (psel && penable && pready && pwrite && paddr == ftc_pkg::ADDR_CTRL)
            ctrl_q <= pwdata[1:0];
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_gts_full;
        (mode_q == ftc_pkg::MODE_GTS && gts_cnt_q == GTS_LIM);
    endsequence
    sequence s_gts_quiet;
        !sby_eff && en_eff && !wake_evt;
    endsequence

    property p_txd_to;
        $rose(txd_to_q) |-> $past(txd_cnt_q) == TXD_LIM ##1 !drive_h && !drive_l;
    endproperty
    a_txd_to: assert property (p_txd_to) else $error("timeout not at limit");

    property p_err_fail;
        (mode_q == ftc_pkg::MODE_NORMAL && (wire_h_f || otemp_s)) |=> !err_n;
    endproperty
    a_err_fail: assert property (p_err_fail) else $error("err_n not low on failure");

    property p_wire_off;
        wire_h_f |=> !term_h_en && !drive_h;
    endproperty
    a_wire_off: assert property (p_wire_off) else $error("faulty wire still on");

    property p_sleep_float;
        (mode_d == ftc_pkg::MODE_SLEEP && !vbat_low_s) |=> !regulator_switch_oe;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("switch driven in sleep");

    property p_stby_high;
        mode_q == ftc_pkg::MODE_STANDBY |-> regulator_switch_oe && regulator_switch_out;
    endproperty
    a_stby_high: assert property (p_stby_high) else $error("switch low in standby");

    property p_pwron_clr;
        (mode_q == ftc_pkg::MODE_NORMAL && !vbat_low_s) |=> !pwron_q;
    endproperty
    a_pwron_clr: assert property (p_pwron_clr) else $error("power-on flag kept");

    property p_gts_sleep;
        s_gts_full ##0 s_gts_quiet |=> mode_q == ftc_pkg::MODE_SLEEP;
    endproperty
    a_gts_sleep: assert property (p_gts_sleep) else $error("no sleep after hold");

    property p_gts_wake;
        (mode_q == ftc_pkg::MODE_GTS && wake_evt && !sby_eff)
            |=> mode_q == ftc_pkg::MODE_STANDBY ##1 regulator_switch_oe;
    endproperty
    a_gts_wake: assert property (p_gts_wake) else $error("wake lost in go-to-sleep");

    property p_vcc_force;
        vcc_low_s |=> mode_q != ftc_pkg::MODE_NORMAL;
    endproperty
    a_vcc_force: assert property (p_vcc_force) else $error("normal with low vcc");

    property p_otemp;
        otemp_s [*2] |=> !drive_h && !drive_l;
    endproperty
    a_otemp: assert property (p_otemp) else $error("drivers on in overtemp");
endmodule

/* bench/ftc_host.sv */
/*
 * ftc_host: model of the can controller and host driving transmit and mode pins.
 * assumes the bench calls its tasks from the pclk domain.
 */
`timescale 1ns/1ps
module ftc_host (
    input  wire logic pclk,
    output logic      txd_n,
    output logic      standby_ctrl_n,
    output logic      mode_en
);
    // ==========================================================
    // idle: recessive, standby selected, as after power-up
    initial begin
        txd_n = 1'b1;
        standby_ctrl_n = 1'b0;
        mode_en = 1'b0;
    end
    // mode pins change just after an edge and then stay
    task automatic set_mode(input logic s, input logic e);
        @(posedge pclk);
        standby_ctrl_n <= s;
        mode_en <= e;
    endtask
    // transmit data, low is dominant
    task automatic set_txd(input logic v);
        @(posedge pclk);
        txd_n <= v;
    endtask
endmodule

/* bench/fault_tolerant_can_phy_ctrl_bench.sv */
/*
 * fault_tolerant_can_phy_ctrl_bench: directed tests of ftc_ctrl.
 * assumes ftc_pkg, the design files and ftc_host are compiled first.
 */
`timescale 1ns/1ps
module fault_tolerant_can_phy_ctrl_bench;
    // ==========================================================
    // stimulus and observed signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic wake_pin = 1'b0, bus_rx = 1'b1, bus_dom_h = 1'b0, bus_dom_l = 1'b0, e;
    logic fail_soft = 1'b0, fail_wire_h = 1'b0, fail_wire_l = 1'b0;
    logic vcc_low = 1'b0, vbat_low = 1'b0, overtemp = 1'b0;
    logic pready, pslverr, txd_n, standby_ctrl_n, mode_en, rxd, err_n;
    logic drive_h, drive_l, term_h_en, term_l_en, low_line_termination;
    logic regulator_switch_out, regulator_switch_oe;
    int fails = 0;
    int checks = 0;
    // short timeout keeps the run small
    ftc_ctrl #(.TXD_TO_CYC(50)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txd_n(txd_n), .standby_ctrl_n(standby_ctrl_n),
        .mode_en(mode_en), .rxd(rxd), .err_n(err_n), .wake_pin(wake_pin),
        .bus_rx(bus_rx), .bus_dom_h(bus_dom_h), .bus_dom_l(bus_dom_l),
        .fail_soft(fail_soft), .fail_wire_h(fail_wire_h), .fail_wire_l(fail_wire_l),
        .vcc_low(vcc_low), .vbat_low(vbat_low), .overtemp(overtemp),
        .drive_h(drive_h), .drive_l(drive_l), .term_h_en(term_h_en),
        .term_l_en(term_l_en), .low_line_termination(low_line_termination),
        .regulator_switch_out(regulator_switch_out),
        .regulator_switch_oe(regulator_switch_oe)
    );
    ftc_host u_host (
        .pclk(pclk), .txd_n(txd_n), .standby_ctrl_n(standby_ctrl_n), .mode_en(mode_en)
    );
    // ==========================================================
    // clock, 25 ns period
    always #12.5 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // apb transfer; only the watchdog bounds the wait on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st();
        apb(1'b0, ftc_pkg::ADDR_STATUS, 32'h0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // watchdog, well above the ~9600 cycles the tests need
    initial begin
        #(50000 * 25);
        fails++;
        report_and_stop();
    end
    // main sequence
    initial begin
        cyc(8);
        presetn <= 1'b1;
        st();
        chk(r[4:0], 5'h08);
        chk(r[12], 1'b1);
        chk(regulator_switch_oe, 1'b1);
        chk(low_line_termination, 1'b1);
        apb(1'b0, ftc_pkg::ADDR_CTRL, 32'h0);
        chk(r, 32'h3);
        apb(1'b0, 8'h08, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        $display("test reset done");
        u_host.set_mode(1'b1, 1'b0);
        cyc(10);
        chk(err_n, 1'b0);
        u_host.set_mode(1'b1, 1'b1);
        cyc(10);
        chk(err_n, 1'b1);
        st();
        chk({r[12], r[4:0]}, 6'h01);
        $display("test power-on done");
        u_host.set_txd(1'b0);
        cyc(10);
        chk({drive_h, drive_l}, 2'h3);
        cyc(60);
        chk({drive_h, drive_l}, 2'h0);
        st();
        chk(r[11], 1'b1);
        u_host.set_txd(1'b1);
        $display("test timeout done");
        fail_wire_h <= 1'b1;
        cyc(1500);
        chk({err_n, term_h_en}, 2'h3);
        cyc(200);
        chk({err_n, term_h_en, term_l_en}, 3'h1);
        fail_wire_h <= 1'b0;
        cyc(1500);
        chk(term_h_en, 1'b0);
        cyc(200);
        chk({err_n, term_h_en}, 2'h3);
        fail_soft <= 1'b1;
        cyc(1700);
        chk({err_n, term_h_en, term_l_en}, 3'h3);
        fail_soft <= 1'b0;
        cyc(1700);
        $display("test failures done");
        overtemp <= 1'b1;
        u_host.set_txd(1'b0);
        cyc(10);
        chk({err_n, drive_h}, 2'h0);
        overtemp <= 1'b0;
        u_host.set_txd(1'b1);
        cyc(10);
        chk(err_n, 1'b1);
        $display("test thermal done");
        u_host.set_mode(1'b0, 1'b1);
        cyc(6);
        st();
        chk({regulator_switch_oe, r[4:0]}, 6'h24);
        cyc(300);
        chk({regulator_switch_oe, low_line_termination}, 2'h1);
        wake_pin <= 1'b1;
        cyc(200);
        chk(regulator_switch_oe, 1'b0);
        cyc(100);
        chk({regulator_switch_oe, rxd, err_n}, 3'h4);
        u_host.set_mode(1'b1, 1'b1);
        cyc(10);
        chk({rxd, err_n}, 2'h3);
        u_host.set_mode(1'b0, 1'b1);
        cyc(300);
        bus_dom_l <= 1'b1;
        cyc(1700);
        bus_dom_l <= 1'b0;
        chk(regulator_switch_oe, 1'b1);
        $display("test wake done");
        u_host.set_mode(1'b1, 1'b1);
        vcc_low <= 1'b1;
        cyc(10);
        st();
        chk(r[0], 1'b0);
        vcc_low <= 1'b0;
        vbat_low <= 1'b1;
        cyc(10);
        st();
        chk({regulator_switch_oe, r[12], r[0]}, 3'h6);
        $display("test supplies done");
        report_and_stop();
    end
endmodule
